/* core/ehs_pkg.sv */
// constants, states and register layout of the exception sequencer
// assumes one system clock and software access over apb
package ehs_pkg;

  localparam int VEC_W = 7;
  localparam int ADDR_W = 24;
  localparam int MSTOP_W = 8;

  // vector numbers
  localparam logic [VEC_W-1:0] VEC_RESET = 7'h00;
  localparam logic [VEC_W-1:0] VEC_TRACE = 7'h05;
  localparam logic [VEC_W-1:0] VEC_DIRECT = 7'h06;
  localparam logic [VEC_W-1:0] VEC_NMI = 7'h07;
  localparam logic [VEC_W-1:0] VEC_TRAP0 = 7'h08;
  localparam logic [VEC_W-1:0] VEC_EXT0 = 7'h10;
  localparam logic [VEC_W-1:0] VEC_INT0 = 7'h18;

  // interrupt control mode codes
  localparam logic [1:0] MODE_0 = 2'h0;
  localparam logic [1:0] MODE_2 = 2'h2;
  localparam logic [2:0] MASK_MAX = 3'h7;

  // reset values
  localparam logic [MSTOP_W-1:0] MSTOP_A_RST = 8'h3F;
  localparam logic [MSTOP_W-1:0] MSTOP_B_RST = 8'hFF;
  localparam logic [MSTOP_W-1:0] MSTOP_C_RST = 8'hFF;
  localparam logic ADV_RST = 1'b1;

  // register offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_MSTOP_A = 8'h04;
  localparam logic [7:0] OFS_MSTOP_B = 8'h08;
  localparam logic [7:0] OFS_MSTOP_C = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;

  // control register fields
  localparam int CB_MODE = 0;
  localparam int CB_ADV = 2;
  localparam int CB_T = 3;
  localparam int CB_MASK = 4;
  localparam int CB_I = 7;
  localparam int CB_UI = 8;

  typedef enum logic [1:0] {ST_RESET, ST_RUN, ST_EXC} ehs_state_t;
  typedef enum logic [2:0] {
    EK_NONE, EK_RESET, EK_TRACE, EK_DIRECT, EK_IRQ, EK_TRAP
  } ehs_kind_t;

endpackage

/* core/ehs_top.sv */
// exception handling sequencer: ranks and starts exceptions
// assumes the pipeline pulses its events on this clock and that
// the reset pin arrives asynchronously
`timescale 1ns/100ps

module ehs_top
  import ehs_pkg::*;
#(
  parameter int APB_AW = 8
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // reset pin and watchdog
  input wire logic reset_pin_n,
  input wire logic wdt_overflow,
  // cpu pipeline
  input wire logic instr_done,
  input wire logic instr_is_rte,
  input wire logic instr_is_ccr_ld,
  input wire logic sleep_direct,
  input wire logic trap_exec,
  input wire logic [1:0] trap_num,
  input wire logic exc_done,
  // interrupt controller
  input wire logic irq_req,
  input wire logic irq_nmi,
  input wire logic [VEC_W-1:0] irq_vector,
  input wire logic [2:0] irq_level,
  output logic irq_ack,
  // exception start
  output logic cpu_halt,
  output logic exc_start,
  output logic [VEC_W-1:0] exc_vector,
  output logic [ADDR_W-1:0] exc_vec_addr,
  output logic ctx_push,
  // control state
  output logic int_ctrl_mode_hi,
  output logic int_ctrl_mode_lo,
  output logic exr_trace_en,
  output logic [2:0] extended_mask_level,
  output logic ccr_int_mask,
  output logic user_mask_bit,
  // module stop and pins
  output logic [MSTOP_W-1:0] module_stop_ctrl_a,
  output logic [MSTOP_W-1:0] module_stop_ctrl_b,
  output logic [MSTOP_W-1:0] module_stop_ctrl_c,
  output logic [3*MSTOP_W-1:0] periph_access_en,
  output logic ext_bus_en,
  output logic port_gpio_en,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  ////////////////////////////////////////////////////////////////////
  // declarations

  logic rpin_s1_q, rpin_s2_q, rpin_q;
  ehs_state_t st_q, st_d;
  ehs_kind_t kind_q, sel_kind;
  logic [1:0] mode_q;
  logic adv_q, exr_t_q, ccr_i_q, ui_q;
  logic [2:0] mask_q;
  logic [MSTOP_W-1:0] mstop_a_q, mstop_b_q, mstop_c_q;
  logic trace_pend_q, direct_pend_q, trap_pend_q, bnd_q;
  logic [1:0] trap_num_q;
  logic start_q, ack_q, push_q;
  logic [VEC_W-1:0] vec_q;
  logic [ADDR_W-1:0] addr_q;
  logic [31:0] prdata_q;

  ////////////////////////////////////////////////////////////////////
  // reset pin synchroniser and reset start

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rpin_s1_q <= 1'b0;
      rpin_s2_q <= 1'b0;
      rpin_q <= 1'b0;
    end else begin
      rpin_s1_q <= reset_pin_n;
      rpin_s2_q <= rpin_s1_q;
      rpin_q <= rpin_s2_q;
    end
  end

  wire held = ~rpin_s2_q;
  wire rise = rpin_s2_q & ~rpin_q;
  wire rst_start = rise | (wdt_overflow & rpin_s2_q);
  wire in_run = (st_q == ST_RUN);
  wire in_exc = (st_q == ST_EXC);

  ////////////////////////////////////////////////////////////////////
  // event conditions and ranking

  wire trace_on = (mode_q == MODE_2) & exr_t_q;
  wire trace_set = in_run & instr_done & trace_on & ~instr_is_rte;
  wire bnd_set = (in_run & instr_done & ~instr_is_ccr_ld)
               | (in_exc & exc_done & (kind_q != EK_RESET));
  wire lvl_ok = (mode_q == MODE_2) ? (irq_level > mask_q) : ~ccr_i_q;
  wire irq_ok = irq_req & (irq_nmi | lvl_ok);

  wire take_trace = in_run & trace_pend_q;
  wire take_direct = in_run & ~trace_pend_q & direct_pend_q;
  wire take_irq = in_run & ~trace_pend_q & ~direct_pend_q & bnd_q
                & irq_ok;
  wire take_trap = in_run & ~trace_pend_q & ~direct_pend_q & ~take_irq
                 & trap_pend_q;
  wire take_any = take_trace | take_direct | take_irq | take_trap;
  wire take = take_any & ~rst_start & ~held;

  wire [VEC_W-1:0] irq_vec = irq_nmi ? VEC_NMI : irq_vector;
  wire [VEC_W-1:0] trap_vec = VEC_TRAP0 + {5'h0, trap_num_q};
  wire [VEC_W-1:0] sel_vec = take_trace ? VEC_TRACE
                           : take_direct ? VEC_DIRECT
                           : take_irq ? irq_vec : trap_vec;
  wire [VEC_W-1:0] vec_in = rst_start ? VEC_RESET : sel_vec;
  wire [ADDR_W-1:0] addr_in = adv_q ? ADDR_W'({vec_in, 2'b00})
                                    : ADDR_W'({vec_in, 1'b0});
  wire [2:0] new_mask = irq_nmi ? MASK_MAX : irq_level;

  always_comb begin
    sel_kind = EK_TRAP;
    if (take_trace) begin
      sel_kind = EK_TRACE;
    end else if (take_direct) begin
      sel_kind = EK_DIRECT;
    end else if (take_irq) begin
      sel_kind = EK_IRQ;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // sequencer state

  always_comb begin
    st_d = st_q;
    case (st_q)
      ST_RESET: begin
        if (rise) begin
          st_d = ST_EXC;
        end
      end
      ST_RUN: begin
        if (rst_start || take_any) begin
          st_d = ST_EXC;
        end
      end
      ST_EXC: begin
        if (rst_start) begin
          st_d = ST_EXC;
        end else if (exc_done) begin
          st_d = ST_RUN;
        end
      end
      default: st_d = ST_RESET;
    endcase
    if (held) begin
      st_d = ST_RESET;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_q <= ST_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // pending events, set wins over clear by take; held pin or reset start clears all

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      trace_pend_q <= 1'b0;
      direct_pend_q <= 1'b0;
      trap_pend_q <= 1'b0;
      trap_num_q <= 2'h0;
      bnd_q <= 1'b0;
    end else if (held || rst_start) begin
      trace_pend_q <= 1'b0;
      direct_pend_q <= 1'b0;
      trap_pend_q <= 1'b0;
      bnd_q <= 1'b0;
    end else begin
      trace_pend_q <= (trace_pend_q & trace_on & ~take_trace) | trace_set;
      direct_pend_q <= (direct_pend_q & ~take_direct)
                     | (in_run & sleep_direct);
      trap_pend_q <= (trap_pend_q & ~take_trap) | (in_run & trap_exec);
      if (in_run && trap_exec) begin
        trap_num_q <= trap_num;
      end
      bnd_q <= bnd_set;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // exception start outputs

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      start_q <= 1'b0;
      ack_q <= 1'b0;
      push_q <= 1'b0;
      vec_q <= VEC_RESET;
      addr_q <= '0;
      kind_q <= EK_NONE;
    end else begin
      start_q <= ~held & (rst_start | take_any);
      ack_q <= take & take_irq;
      push_q <= take;
      if (!held && (rst_start || take_any)) begin
        vec_q <= vec_in;
        addr_q <= addr_in;
        kind_q <= rst_start ? EK_RESET : sel_kind;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // apb decode

  wire setup = psel & ~penable;
  wire acc = psel & penable;
  wire hit_ctrl = (paddr == APB_AW'(OFS_CTRL));
  wire hit_a = (paddr == APB_AW'(OFS_MSTOP_A));
  wire hit_b = (paddr == APB_AW'(OFS_MSTOP_B));
  wire hit_c = (paddr == APB_AW'(OFS_MSTOP_C));
  wire hit_st = (paddr == APB_AW'(OFS_STATUS));
  wire hit = hit_ctrl | hit_a | hit_b | hit_c | hit_st;
  wire wr = acc & pwrite;
  wire [1:0] wmode = pwdata[CB_MODE +: 2];
  wire mode_legal = (wmode == MODE_0) | (wmode == MODE_2);
  wire [31:0] ctrl_word = {23'h0, ui_q, ccr_i_q, mask_q, exr_t_q,
                           adv_q, mode_q};
  wire [31:0] stat_word = {20'h0, st_q, kind_q, vec_q};
  wire [31:0] rd_word = hit_ctrl ? ctrl_word
                      : hit_a ? {24'h0, mstop_a_q}
                      : hit_b ? {24'h0, mstop_b_q}
                      : hit_c ? {24'h0, mstop_c_q}
                      : hit_st ? stat_word : 32'h0000_0000;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup) begin
      prdata_q <= rd_word;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // control bits: reset, exception updates, then software writes

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mode_q <= MODE_0;
      adv_q <= ADV_RST;
      exr_t_q <= 1'b0;
      ccr_i_q <= 1'b1;
      ui_q <= 1'b0;
      mask_q <= MASK_MAX;
    end else if (held || rst_start) begin
      mode_q <= MODE_0;
      exr_t_q <= 1'b0;
      ccr_i_q <= 1'b1;
      mask_q <= MASK_MAX;
    end else if (take) begin
      ccr_i_q <= 1'b1;
      if (take_irq && mode_q == MODE_2) begin
        mask_q <= new_mask;
      end
      if (mode_q == MODE_2 || !take_trap) begin
        exr_t_q <= 1'b0;
      end
    end else if (wr && hit_ctrl) begin
      if (mode_legal) begin
        mode_q <= wmode;
      end
      adv_q <= pwdata[CB_ADV];
      exr_t_q <= pwdata[CB_T];
      mask_q <= pwdata[CB_MASK +: 3];
      ccr_i_q <= pwdata[CB_I];
      ui_q <= pwdata[CB_UI];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mstop_a_q <= MSTOP_A_RST;
      mstop_b_q <= MSTOP_B_RST;
      mstop_c_q <= MSTOP_C_RST;
    end else if (held || rst_start) begin
      mstop_a_q <= MSTOP_A_RST;
      mstop_b_q <= MSTOP_B_RST;
      mstop_c_q <= MSTOP_C_RST;
    end else if (wr) begin
      if (hit_a) begin
        mstop_a_q <= pwdata[MSTOP_W-1:0];
      end
      if (hit_b) begin
        mstop_b_q <= pwdata[MSTOP_W-1:0];
      end
      if (hit_c) begin
        mstop_c_q <= pwdata[MSTOP_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // outputs

  assign irq_ack = ack_q;
  assign cpu_halt = (st_q == ST_RESET);
  assign exc_start = start_q;
  assign exc_vector = vec_q;
  assign exc_vec_addr = addr_q;
  assign ctx_push = push_q;
  assign int_ctrl_mode_hi = mode_q[1];
  assign int_ctrl_mode_lo = mode_q[0];
  assign exr_trace_en = exr_t_q;
  assign extended_mask_level = mask_q;
  assign ccr_int_mask = ccr_i_q;
  assign user_mask_bit = ui_q;
  assign module_stop_ctrl_a = mstop_a_q;
  assign module_stop_ctrl_b = mstop_b_q;
  assign module_stop_ctrl_c = mstop_c_q;
  assign periph_access_en = ~{mstop_c_q, mstop_b_q, mstop_a_q};
  assign ext_bus_en = 1'b0;
  assign port_gpio_en = 1'b1;
  assign prdata = prdata_q;
  assign pready = 1'b1;
  assign pslverr = acc & ~hit;

  ////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  property p_halt;
    held |=> cpu_halt;
  endproperty
  a_halt: assert property (p_halt)
    else $error("pin held low but cpu not halted");

  property p_rst_start;
    rise |=> exc_start && exc_vector == VEC_RESET && !ctx_push;
  endproperty
  a_rst_start: assert property (p_rst_start)
    else $error("reset handling did not start on pin rise");

  property p_rst_bits;
    rise |=> !exr_trace_en && ccr_int_mask && !int_ctrl_mode_hi
             && !int_ctrl_mode_lo;
  endproperty
  a_rst_bits: assert property (p_rst_bits)
    else $error("control bits wrong after reset");

  property p_no_irq_reset;
    exc_done && in_exc && kind_q == EK_RESET |=> ##1 !irq_ack;
  endproperty
  a_no_irq_reset: assert property (p_no_irq_reset)
    else $error("interrupt taken right after reset handling");

  property p_trace_mode;
    exc_start && kind_q == EK_TRACE |-> $past(mode_q) == MODE_2;
  endproperty
  a_trace_mode: assert property (p_trace_mode)
    else $error("trace started outside mode 2");

  property p_prio;
    take_trace && bnd_q && irq_ok |=> exc_vector == VEC_TRACE;
  endproperty
  a_prio: assert property (p_prio)
    else $error("interrupt beat a pending trace");

  property p_addr;
    exc_start && adv_q |-> exc_vec_addr == ADDR_W'({exc_vector, 2'b00});
  endproperty
  a_addr: assert property (p_addr)
    else $error("advanced vector address wrong");

  property p_trace_bits;
    exc_start && kind_q == EK_TRACE |-> ccr_int_mask && !exr_trace_en;
  endproperty
  a_trace_bits: assert property (p_trace_bits)
    else $error("trace handling left wrong mask bits");

  property p_rte;
    in_run && instr_done && instr_is_rte && !trace_pend_q |=> !trace_pend_q;
  endproperty
  a_rte: assert property (p_rte)
    else $error("trace pending after return instruction");

  property p_mstop;
    rise |=> module_stop_ctrl_a == MSTOP_A_RST
             && module_stop_ctrl_b == MSTOP_B_RST
             && module_stop_ctrl_c == MSTOP_C_RST;
  endproperty
  a_mstop: assert property (p_mstop)
    else $error("modules not stopped after reset");

endmodule

/* tb/ehs_partner_model.sv */
// far side of the sequencer: interrupt controller and cpu pipeline end
// assumes the bench commands requests; the cpu ends each handling later
`timescale 1ns/100ps

module ehs_partner_model
  import ehs_pkg::*;
#(
  parameter int DONE_DLY = 3
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // bench commands
  input wire logic req_set,
  input wire logic req_nmi,
  input wire logic [VEC_W-1:0] req_vec,
  input wire logic [2:0] req_lvl,
  // sequencer side
  input wire logic exc_start,
  input wire logic irq_ack,
  output logic irq_req,
  output logic irq_nmi,
  output logic [VEC_W-1:0] irq_vector,
  output logic [2:0] irq_level,
  output logic exc_done
);
  logic [VEC_W-1:0] vec_q;
  logic [2:0] lvl_q;
  logic nmi_q;
  int cnt_q;

  ////////////////////////////////////////////////////////////////////////
  // request stays up until accepted
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      irq_req <= 1'b0;
      vec_q <= '0;
      lvl_q <= '0;
      nmi_q <= 1'b0;
    end else begin
      if (irq_ack) begin
        irq_req <= 1'b0;
      end else if (req_set) begin
        irq_req <= 1'b1;
      end
      if (req_set) begin
        vec_q <= req_vec;
        lvl_q <= req_lvl;
        nmi_q <= req_nmi;
      end
    end
  end

  // released lines show the inverse of their last value
  assign irq_vector = irq_req ? vec_q : ~vec_q;
  assign irq_level = irq_req ? lvl_q : ~lvl_q;
  assign irq_nmi = irq_req ? nmi_q : ~nmi_q;

  ////////////////////////////////////////////////////////////////////////
  // cpu ends each handling a few cycles after its start
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt_q <= 0;
    end else if (exc_start) begin
      cnt_q <= DONE_DLY;
    end else if (cnt_q != 0) begin
      cnt_q <= cnt_q - 1;
    end
  end
  assign exc_done = (cnt_q == 1);
endmodule

/* tb/tb.sv */
// self-checking bench of the exception sequencer over apb and pipeline
// assumes the partner model ends handlings and holds requests
`timescale 1ns/100ps

module tb
  import ehs_pkg::*;
;
  logic clock, rst, reset_pin_n, wdt_overflow;
  logic instr_done, instr_is_rte, instr_is_ccr_ld, sleep_direct, trap_exec;
  logic [1:0] trap_num;
  logic exc_done, irq_req, irq_nmi, irq_ack, cpu_halt, exc_start, ctx_push;
  logic [VEC_W-1:0] irq_vector, exc_vector, req_vec;
  logic [2:0] irq_level, req_lvl, extended_mask_level;
  logic [ADDR_W-1:0] exc_vec_addr;
  logic req_set, req_nmi, int_ctrl_mode_hi, int_ctrl_mode_lo;
  logic exr_trace_en, ccr_int_mask, user_mask_bit, ext_bus_en, port_gpio_en;
  logic [MSTOP_W-1:0] module_stop_ctrl_a, module_stop_ctrl_b;
  logic [MSTOP_W-1:0] module_stop_ctrl_c;
  logic [3*MSTOP_W-1:0] periph_access_en;
  logic psel, penable, pwrite, pready, pslverr, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  int err_total, check_count;

  ehs_top ehs_top_inst (.clock, .rst, .reset_pin_n, .wdt_overflow,
    .instr_done, .instr_is_rte, .instr_is_ccr_ld, .sleep_direct,
    .trap_exec, .trap_num, .exc_done, .irq_req, .irq_nmi, .irq_vector,
    .irq_level, .irq_ack, .cpu_halt, .exc_start, .exc_vector,
    .exc_vec_addr, .ctx_push, .int_ctrl_mode_hi, .int_ctrl_mode_lo,
    .exr_trace_en, .extended_mask_level, .ccr_int_mask, .user_mask_bit,
    .module_stop_ctrl_a, .module_stop_ctrl_b, .module_stop_ctrl_c,
    .periph_access_en, .ext_bus_en, .port_gpio_en, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);

  ehs_partner_model ehs_partner_model_inst (.clock, .rst, .req_set,
    .req_nmi, .req_vec, .req_lvl, .exc_start, .irq_ack, .irq_req,
    .irq_nmi, .irq_vector, .irq_level, .exc_done);

  ////////////////////////////////////////////////////////////////////////
  task final_report;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task chk(input string n, input logic [31:0] s, input logic [31:0] x);
    check_count++;
    if (s !== x) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", n, x, s);
    end
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task rdc(input string n, input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0000_0000);
    chk(n, rd, x);
  endtask

  // one-cycle pulse of done, rte, ccr load, sleep, trap
  task pipe(input logic [4:0] m);
    @(posedge clock);
    {instr_done, instr_is_rte, instr_is_ccr_ld, sleep_direct, trap_exec}
      <= m;
    @(posedge clock);
    {instr_done, instr_is_rte, instr_is_ccr_ld, sleep_direct, trap_exec}
      <= 5'h0;
  endtask

  task wexc(input logic [6:0] v, input logic [23:0] ad, input logic pu,
            input logic ak);
    int i;
    i = 0;
    #1;
    while (exc_start !== 1'b1 && i < 30) begin
      @(posedge clock);
      #1;
      i++;
    end
    chk("start", exc_start, 1'b1);
    chk("vector", exc_vector, v);
    chk("address", exc_vec_addr, ad);
    chk("push", ctx_push, pu);
    chk("ack", irq_ack, ak);
    @(posedge clock);
    #1;
  endtask

  task quiet(input int n);
    logic seen;
    seen = 1'b0;
    repeat (n) begin
      @(posedge clock);
      #1;
      seen = seen | exc_start | irq_ack;
    end
    chk("quiet", seen, 1'b0);
  endtask

  task req(input logic nm, input logic [6:0] v, input logic [2:0] l);
    @(posedge clock);
    req_set <= 1'b1;
    req_nmi <= nm;
    req_vec <= v;
    req_lvl <= l;
    @(posedge clock);
    req_set <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  initial begin
    repeat (4000) @(posedge clock);
    err_total++;
    final_report;
  end

  initial begin
    {rst, reset_pin_n, wdt_overflow, trap_num, req_set, req_nmi} = 7'h40;
    {instr_done, instr_is_rte, instr_is_ccr_ld, sleep_direct, trap_exec} = 0;
    {req_vec, req_lvl, psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    rdc("ctrl", OFS_CTRL, 32'h0000_00f4);
    rdc("stop a", OFS_MSTOP_A, 32'h0000_003f);
    rdc("stop b", OFS_MSTOP_B, 32'h0000_00ff);
    rdc("stop c", OFS_MSTOP_C, 32'h0000_00ff);
    chk("access", periph_access_en, 32'h0000_00c0);
    chk("ext bus", ext_bus_en, 1'b0);
    chk("gpio", port_gpio_en, 1'b1);
    req(1'b1, 7'h00, 3'h0);
    repeat (20) @(posedge clock); // pin low for 20 more states, 39 since time zero
    chk("halt", cpu_halt, 1'b1);
    reset_pin_n <= 1'b1;
    wexc(VEC_RESET, 24'h00_0000, 1'b0, 1'b0);
    chk("halt", cpu_halt, 1'b0);
    quiet(8);
    pipe(5'h10); // first instruction loads the stack pointer
    wexc(VEC_NMI, 24'h00_001c, 1'b1, 1'b1);
    $display("test reset done");
    apb(1'b1, OFS_CTRL, 32'h0000_000c);
    pipe(5'h10);
    quiet(8);
    req(1'b0, 7'h18, 3'h1);
    pipe(5'h14);
    quiet(8);
    pipe(5'h10);
    wexc(7'h18, 24'h00_0060, 1'b1, 1'b1);
    chk("trace bit", exr_trace_en, 1'b0);
    apb(1'b1, OFS_CTRL, 32'h0000_0000);
    trap_num <= 2'h3;
    pipe(5'h01);
    wexc(7'h0b, 24'h00_0016, 1'b1, 1'b0);
    $display("test mode 0 done");
    apb(1'b1, OFS_CTRL, 32'h0000_0001);
    rdc("ctrl", OFS_CTRL, 32'h0000_0000);
    apb(1'b1, OFS_CTRL, 32'h0000_000e);
    rdc("ctrl", OFS_CTRL, 32'h0000_000e);
    apb(1'b1, OFS_CTRL, 32'h0000_000f);
    rdc("ctrl", OFS_CTRL, 32'h0000_000e);
    pipe(5'h18);
    quiet(8);
    req(1'b0, VEC_EXT0, 3'h3);
    trap_num <= 2'h1;
    pipe(5'h13);
    wexc(VEC_TRACE, 24'h00_0014, 1'b1, 1'b0);
    chk("trace bit", exr_trace_en, 1'b0);
    chk("ccr mask", ccr_int_mask, 1'b1);
    chk("level", extended_mask_level, 3'h0);
    chk("user bit", user_mask_bit, 1'b0);
    wexc(VEC_DIRECT, 24'h00_0018, 1'b1, 1'b0);
    wexc(VEC_EXT0, 24'h00_0040, 1'b1, 1'b1);
    chk("level", extended_mask_level, 3'h3);
    wexc(7'h09, 24'h00_0024, 1'b1, 1'b0);
    $display("test mode 2 done");
    apb(1'b1, OFS_MSTOP_A, 32'h0000_0000);
    rdc("stop a", OFS_MSTOP_A, 32'h0000_0000);
    chk("access", periph_access_en, 32'h0000_00ff);
    apb(1'b1, 8'h20, 32'h0000_ffff);
    rdc("unmapped", 8'h20, 32'h0000_0000);
    chk("slverr", er, 1'b1);
    @(posedge clock);
    wdt_overflow <= 1'b1;
    @(posedge clock);
    wdt_overflow <= 1'b0;
    wexc(VEC_RESET, 24'h00_0000, 1'b0, 1'b0);
    rdc("ctrl", OFS_CTRL, 32'h0000_00f4);
    $display("test watchdog done");
    final_report;
  end
endmodule
